/* src/ctsr_regs_top.v */
// Collision display, transmit length, bit-rate and converter registers
// behind an AXI4-Lite slave, with a sticky interrupt status and mask.
// Assumes framing, receiver and converter logic drive the event inputs
// synchronous to clk; setDefault is a one-cycle pulse.
//
// How it works
// - Collision register bits 7:4 hold full bytes
// - Bits 3:1 hold bits before collision
// - Bit 0 flags collision on parity bit
// - Longer frames leave collision register unchanged
// - Status registers clear at reset, set-default
// - Byte count is 13 bits over two registers
// - Up to 8191 complete bytes per command
// - Low three bits count split-byte bits
// - Split final byte sent without parity
// - Parity interrupt on WUPA when misconfigured
// - Length registers reset zero, read-write
// - Detected bit rate in bits 7:4
// - Last converter result readable
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ctsr_regs.vh"
module ctsr_regs_top (
  input wire clk,
  input wire rst_b,
  // AXI4-Lite write address
  input wire [7:0] awaddr,
  input wire awvalid,
  output reg awready,
  // Write data
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  // Write response
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // Read address
  input wire [7:0] araddr,
  input wire arvalid,
  output reg arready,
  // Read data
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // Set-default command pulse
  input wire setDefault,
  // Receive side collision reporting
  input wire rxFrameStart,
  input wire collisionSeen,
  input wire [3:0] collisionByte,
  input wire [2:0] collisionBit,
  input wire collisionOnParity,
  // Bit-rate detection and converter results
  input wire rateValid,
  input wire [3:0] rateCode,
  input wire adcValid,
  input wire [7:0] adcResult,
  // WUPA direct command pulse
  input wire wupaCommand,
  // Transmit length towards the framer
  output reg [12:0] txByteCount,
  output reg [2:0] txSplitBits,
  output reg txParityEnable,
  output reg irq
);

  // Software-visible register contents
  reg [7:0] collisionPosition;
  reg [7:0] txByteCountHigh;
  reg [7:0] txByteCountLowBits;
  reg [3:0] detectedBitRate;
  reg [7:0] converterResult;

  // Interrupt and control state
  reg [`CTSR_IRQ_W-1:0] irqStatus;
  reg [`CTSR_IRQ_W-1:0] irqMask;
  reg [1:0] ctrl;

  // Set by the first collision, cleared by a new frame
  reg collisionTaken;

  // Write channel holding registers; either half may arrive first
  reg awHeld;
  reg wHeld;
  reg [7:0] awIdx;
  reg [31:0] wHeldData;
  reg [3:0] wHeldStrb;

  // Read mux result, registered on the address handshake
  reg [31:0] next_rdata;
  reg next_rerr;

  // Per-cycle event and clear vectors for the sticky status
  reg [`CTSR_IRQ_W-1:0] irqEvents;
  reg [`CTSR_IRQ_W-1:0] irqClear;

  // One-hot write enables from the write address decode
  reg wrTxHi;
  reg wrTxLo;
  reg wrStat;
  reg wrMask;
  reg wrCtrl;
  reg wrErr;

  // Decoded indices and qualifiers
  wire [7:0] arIdx;
  wire doWrite;
  wire recordCollision;
  wire parityConfigError;
  wire [`CTSR_IRQ_W-1:0] next_irqStatus;

  // Word index from the byte address; low two bits ignored, so
  // unaligned addresses alias onto the word below them
  assign arIdx = {2'b00, araddr[7:2]};
  // Write commits once both halves are held and no response pends
  assign doWrite = awHeld && wHeld && !bvalid;
  // First collision of the frame and within anticollision range
  assign recordCollision = collisionSeen && !collisionTaken &&
    (collisionByte <= `CTSR_ANTICOLL_MAX_BYTES);
  // Split-byte count on an idle card with anticollision set
  assign parityConfigError = wupaCommand && ctrl[`CTSR_CTRL_ANCTL] &&
    ctrl[`CTSR_CTRL_IDLE] && (txByteCountLowBits[2:0] != 3'b000);

  // Write address decode; only byte lane 0 carries register data,
  // so a write without wstrb[0] completes but changes nothing
  always @* begin
    wrTxHi = 1'b0;
    wrTxLo = 1'b0;
    wrStat = 1'b0;
    wrMask = 1'b0;
    wrCtrl = 1'b0;
    wrErr = 1'b0;
    if (awIdx == `CTSR_IDX_TXHI) begin
      wrTxHi = doWrite && wHeldStrb[0];
    end else if (awIdx == `CTSR_IDX_TXLO) begin
      wrTxLo = doWrite && wHeldStrb[0];
    end else if (awIdx == `CTSR_IDX_IRQSTAT) begin
      wrStat = doWrite && wHeldStrb[0];
    end else if (awIdx == `CTSR_IDX_IRQMASK) begin
      wrMask = doWrite && wHeldStrb[0];
    end else if (awIdx == `CTSR_IDX_CTRL) begin
      wrCtrl = doWrite && wHeldStrb[0];
    end else if (awIdx == `CTSR_IDX_COLL || awIdx == `CTSR_IDX_RATE ||
        awIdx == `CTSR_IDX_ADC) begin
      wrErr = 1'b0; // Read-only: write ignored, OKAY
    end else begin
      wrErr = 1'b1;
    end
  end

  // Read address decode; upper bits read as zero
  // A refused read returns zero data so nothing stale leaks out
  always @* begin
    next_rdata = 32'h0000_0000;
    next_rerr = 1'b0;
    if (arIdx == `CTSR_IDX_COLL) begin
      next_rdata[7:0] = collisionPosition;
    end else if (arIdx == `CTSR_IDX_TXHI) begin
      next_rdata[7:0] = txByteCountHigh;
    end else if (arIdx == `CTSR_IDX_TXLO) begin
      next_rdata[7:0] = txByteCountLowBits;
    end else if (arIdx == `CTSR_IDX_RATE) begin
      next_rdata[7:0] = {detectedBitRate, 4'h0};
    end else if (arIdx == `CTSR_IDX_ADC) begin
      next_rdata[7:0] = converterResult;
    end else if (arIdx == `CTSR_IDX_IRQSTAT) begin
      next_rdata[`CTSR_IRQ_W-1:0] = irqStatus;
    end else if (arIdx == `CTSR_IDX_IRQMASK) begin
      next_rdata[`CTSR_IRQ_W-1:0] = irqMask;
    end else if (arIdx == `CTSR_IDX_CTRL) begin
      next_rdata[1:0] = ctrl;
    end else begin
      next_rerr = 1'b1;
    end
  end

  // Write channel: address and data accepted in either order
  // The readies toggle while idle; a master that holds valid is
  // taken within two cycles, and nothing new is taken while held
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      awready <= 1'b0;
      wready <= 1'b0;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awIdx <= 8'h00;
      wHeldData <= 32'h0000_0000;
      wHeldStrb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `CTSR_RESP_OKAY;
    end else begin
      awready <= !awHeld && !awready;
      wready <= !wHeld && !wready;
      if (awvalid && awready) begin
        awHeld <= 1'b1;
        awIdx <= {2'b00, awaddr[7:2]};
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld <= 1'b1;
        wHeldData <= wdata;
        wHeldStrb <= wstrb;
        wready <= 1'b0;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wrErr ? `CTSR_RESP_SLVERR : `CTSR_RESP_OKAY;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one outstanding read, answer one cycle after address
  // Data is captured at the handshake, so a later register update
  // cannot change an answer that is already standing
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `CTSR_RESP_OKAY;
    end else begin
      arready <= !rvalid && !arready && !(arvalid && arready);
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= next_rdata;
        rresp <= next_rerr ? `CTSR_RESP_SLVERR : `CTSR_RESP_OKAY;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Transmit length registers; set-default wins over a write
  // The two halves are written separately, so the framer can see a
  // mixed count between the writes; software writes both before use
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txByteCountHigh <= `CTSR_RESET_BYTE;
      txByteCountLowBits <= `CTSR_RESET_BYTE;
    end else if (setDefault) begin
      txByteCountHigh <= `CTSR_RESET_BYTE;
      txByteCountLowBits <= `CTSR_RESET_BYTE;
    end else begin
      if (wrTxHi) begin
        txByteCountHigh <= wHeldData[7:0];
      end
      if (wrTxLo) begin
        txByteCountLowBits <= wHeldData[7:0];
      end
    end
  end

  // Length outputs registered so the framer sees a settled value;
  // 13 bits cover the 8191-byte ceiling exactly
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txByteCount <= 13'h0000;
      txSplitBits <= 3'b000;
      txParityEnable <= 1'b1;
    end else begin
      txByteCount <= {txByteCountHigh, txByteCountLowBits[7:3]};
      txSplitBits <= txByteCountLowBits[2:0];
      // A split last byte means bit-oriented frame: no parity
      txParityEnable <= (txByteCountLowBits[2:0] == 3'b000);
    end
  end

  // Collision position, captured once per frame
  // A frame start in the same cycle as a collision rearms capture and keeps
  // that collision out of the register, though its interrupt sets if capture was already armed;
  // the receiver never issues both at once
  // An out-of-range collision still counts as the first one
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      collisionPosition <= `CTSR_RESET_BYTE;
      collisionTaken <= 1'b0;
    end else if (setDefault) begin
      collisionPosition <= `CTSR_RESET_BYTE;
      collisionTaken <= 1'b0;
    end else if (rxFrameStart) begin
      collisionTaken <= 1'b0;
    end else begin
      if (collisionSeen) begin
        collisionTaken <= 1'b1;
      end
      if (recordCollision) begin
        collisionPosition[`CTSR_COLL_BYTE_HI:`CTSR_COLL_BYTE_LO] <=
          collisionByte;
        collisionPosition[`CTSR_COLL_BIT_HI:`CTSR_COLL_BIT_LO] <=
          collisionBit;
        collisionPosition[`CTSR_COLL_PAR] <= collisionOnParity;
      end
    end
  end

  // Bit-rate and converter result registers
  // Each holds its last value until the next valid pulse or set-default
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      detectedBitRate <= 4'h0;
      converterResult <= `CTSR_RESET_BYTE;
    end else if (setDefault) begin
      detectedBitRate <= 4'h0;
      converterResult <= `CTSR_RESET_BYTE;
    end else begin
      if (rateValid) begin
        detectedBitRate <= rateCode;
      end
      if (adcValid) begin
        converterResult <= adcResult;
      end
    end
  end

  // Interrupt events; parity error on a first collision at the parity bit or WUPA misconfiguration
  always @* begin
    irqEvents = {`CTSR_IRQ_W{1'b0}};
    irqEvents[`CTSR_IRQ_COLL] = recordCollision;
    irqEvents[`CTSR_IRQ_PAR] = (recordCollision && collisionOnParity) ||
      parityConfigError;
    irqEvents[`CTSR_IRQ_RATE] = rateValid;
    irqEvents[`CTSR_IRQ_ADC] = adcValid;
    irqClear = wrStat ? wHeldData[`CTSR_IRQ_W-1:0] : {`CTSR_IRQ_W{1'b0}};
  end

  // Status value after this cycle's events and clears
  assign next_irqStatus = (irqStatus & ~irqClear) | irqEvents;

  // Sticky status per bit, write one to clear
  // A new event beats the clear so no event is ever lost
  genvar g;
  generate
    for (g = 0; g < `CTSR_IRQ_W; g = g + 1) begin : gen_irq_bit
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          irqStatus[g] <= 1'b0;
        end else if (irqEvents[g]) begin
          irqStatus[g] <= 1'b1;
        end else if (irqClear[g]) begin
          irqStatus[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Mask, control and the registered interrupt line
  // Status and mask survive set-default; only control clears
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irqMask <= {`CTSR_IRQ_W{1'b0}};
      ctrl <= 2'b00;
      irq <= 1'b0;
    end else begin
      if (wrMask) begin
        irqMask <= wHeldData[`CTSR_IRQ_W-1:0];
      end
      if (setDefault) begin
        ctrl <= 2'b00;
      end else if (wrCtrl) begin
        ctrl <= wHeldData[1:0];
      end
      // Mask bit high enables the source
      // Built from the next status so irq tracks it without lag
      irq <= |(next_irqStatus & irqMask);
    end
  end

endmodule

/* src/ctsr_regs.vh */
// Register map, field positions and reset values of the collision,
// transmit-length, bit-rate and converter register slice.
// Assumes a 32-bit AXI4-Lite bus with one register per word.
`ifndef CTSR_REGS_VH
`define CTSR_REGS_VH
// Printed offsets are register indices; byte address is index * 4
`define CTSR_IDX_COLL 8'h1C
`define CTSR_IDX_TXHI 8'h1D
`define CTSR_IDX_TXLO 8'h1E
`define CTSR_IDX_RATE 8'h1F
`define CTSR_IDX_ADC 8'h20
`define CTSR_IDX_IRQSTAT 8'h30
`define CTSR_IDX_IRQMASK 8'h31
`define CTSR_IDX_CTRL 8'h32
`define CTSR_RESET_BYTE 8'h00
// Collision register fields
`define CTSR_COLL_BYTE_HI 7
`define CTSR_COLL_BYTE_LO 4
`define CTSR_COLL_BIT_HI 3
`define CTSR_COLL_BIT_LO 1
`define CTSR_COLL_PAR 0
// Longest frame the collision register covers, in full bytes
`define CTSR_ANTICOLL_MAX_BYTES 4'h6
// Interrupt status bits
`define CTSR_IRQ_COLL 0
`define CTSR_IRQ_PAR 1
`define CTSR_IRQ_RATE 2
`define CTSR_IRQ_ADC 3
`define CTSR_IRQ_W 4
// Control register bits
`define CTSR_CTRL_ANCTL 0
`define CTSR_CTRL_IDLE 1
`define CTSR_RESP_OKAY 2'b00
`define CTSR_RESP_SLVERR 2'b10
`endif

/* dv/ctsr_regs_chk.sv */
// Port checker for the collision and transmit-length register slice
// Assumes one clock domain and binding onto ctsr_regs_top
`timescale 1ns/1ps
`include "ctsr_regs.vh"
module ctsr_regs_chk (
  input wire clk,
  input wire rst_b,
  input wire arvalid,
  input wire arready,
  input wire rvalid,
  input wire rready,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  input wire bvalid,
  input wire [1:0] bresp,
  input wire setDefault,
  input wire [12:0] txByteCount,
  input wire [2:0] txSplitBits,
  input wire txParityEnable,
  input wire irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Split last byte turns parity generation off
  AST_TXPAR: assert property (txParityEnable == (txSplitBits == 3'h0))
    else $error("parity enable disagrees with split bits");
  // Length moves only by a bus write or set-default
  AST_TXHOLD: assert property ($changed({txByteCount, txSplitBits}) |->
    bvalid || $past(bvalid) || $past(setDefault, 2))
    else $error("transmit length changed on its own");
  AST_SETDEF: assert property (setDefault |-> ##2 txByteCount == 13'h0 &&
    txSplitBits == 3'h0) else $error("set-default left a length");
  AST_RDHI: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  AST_SLVZ: assert property (rvalid && rresp == `CTSR_RESP_SLVERR |->
    rdata == 32'h0000_0000) else $error("refused read carried data");
  AST_ARANS: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  AST_RCLR: assert property (rvalid && rready |=> !rvalid)
    else $error("read answer outstayed its handshake");
  AST_RDONCE: assert property ($rose(rvalid) |-> $past(arvalid && arready))
    else $error("read answer without request");
  // Main scenarios
  cover property (bvalid && bresp == `CTSR_RESP_SLVERR);
  cover property (rvalid && rdata[7:0] != 8'h00);
  cover property ($rose(irq));
endmodule
bind ctsr_regs_top ctsr_regs_chk chk_u (.clk, .rst_b, .arvalid, .arready,
  .rvalid, .rready, .rdata, .rresp, .bvalid, .bresp, .setDefault,
  .txByteCount, .txSplitBits, .txParityEnable, .irq);

/* dv/tb_collision_txcount_status_regs.sv */
// Self-checking bench driving the register slice over AXI4-Lite
// Assumes ctsr_regs_top with its checker bound in the same compile
`timescale 1ns/1ps
`include "ctsr_regs.vh"
module tb_collision_txcount_status_regs;
  logic clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, setDefault, rxFrameStart;
  logic collisionSeen, collisionOnParity, rateValid, adcValid, wupaCommand;
  logic txParityEnable, irq;
  logic [7:0] awaddr, araddr, adcResult;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, collisionByte, rateCode;
  logic [2:0] collisionBit, txSplitBits;
  logic [1:0] bresp, rresp;
  logic [12:0] txByteCount;
  int n_fail = 0, checks = 0, cyc = 0, i;
  localparam logic [1:0] OK = `CTSR_RESP_OKAY;
  localparam logic [1:0] ERR = `CTSR_RESP_SLVERR;
  ctsr_regs_top dut_u (.clk, .rst_b, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .setDefault, .rxFrameStart,
    .collisionSeen, .collisionByte, .collisionBit, .collisionOnParity,
    .rateValid, .rateCode, .adcValid, .adcResult, .wupaCommand,
    .txByteCount, .txSplitBits, .txParityEnable, .irq);
  // Clock, 10 ns period
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // Hang guard, far above the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      print_verdict;
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Write; address and data offered together, each released when taken
  task wrc(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    fork
      begin
        do @(posedge clk); while (!awready);
        awvalid <= 0;
      end
      begin
        do @(posedge clk); while (!wready);
        wvalid <= 0;
      end
    join
    do @(posedge clk); while (!bvalid);
    bready <= 0;
    chk(bresp, e);
  endtask
  // Read and compare data and response
  task rdc(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge clk); while (!arready);
    arvalid <= 0;
    do @(posedge clk); while (!rvalid);
    rready <= 0;
    chk(rdata, {24'h0, d});
    chk(rresp, e);
  endtask
  // Collision pulse, optionally after a new-frame pulse
  task coll(input logic s, input logic [3:0] b, input logic [2:0] t,
    input logic p);
    @(posedge clk);
    rxFrameStart <= s;
    @(posedge clk);
    rxFrameStart <= 0;
    collisionSeen <= 1;
    collisionByte <= b;
    collisionBit <= t;
    collisionOnParity <= p;
    @(posedge clk);
    collisionSeen <= 0;
  endtask
  task pulse(input int k);
    @(posedge clk);
    if (k == 0) wupaCommand <= 1;
    else setDefault <= 1;
    @(posedge clk);
    wupaCommand <= 0;
    setDefault <= 0;
  endtask
  task print_verdict;
    $display("checks %0d fails %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready, setDefault} = 0;
    {rxFrameStart, collisionSeen, collisionOnParity, rateValid} = 0;
    {adcValid, wupaCommand, awaddr, araddr, adcResult, wdata} = 0;
    {collisionByte, rateCode, collisionBit} = 0;
    wstrb = 4'hF;
    repeat (3) @(posedge clk);
    rst_b <= 1;
    for (i = 0; i < 5; i++) rdc(8'h70 + 8'(4 * i), 8'h00, OK);
    $display("reset values done");
    wrc(8'h74, 8'hFF, OK);
    wrc(8'h78, 8'hFF, OK);
    @(posedge clk);
    chk(txByteCount, 13'h1FFF);
    chk(txSplitBits, 3'h7);
    chk(txParityEnable, 1'b0);
    rdc(8'h78, 8'hFF, OK);
    wrc(8'h78, 8'h08, OK);
    @(posedge clk);
    chk(txByteCount, 13'h1FE1);
    chk(txParityEnable, 1'b1);
    rdc(8'h74, 8'hFF, OK);
    wrc(8'h80, 8'hAA, OK);
    rdc(8'h80, 8'h00, OK);
    wrc(8'h10, 8'h55, ERR);
    rdc(8'h10, 8'h00, ERR);
    $display("length registers done");
    coll(1, 4'h5, 3'h3, 1);
    rdc(8'h70, 8'h57, OK);
    coll(0, 4'h2, 3'h1, 0);
    rdc(8'h70, 8'h57, OK);
    coll(1, 4'h7, 3'h2, 0);
    rdc(8'h70, 8'h57, OK);
    coll(1, 4'h6, 3'h0, 0);
    rdc(8'h70, 8'h60, OK);
    @(posedge clk);
    rateValid <= 1;
    rateCode <= 4'hA;
    adcValid <= 1;
    adcResult <= 8'h5C;
    @(posedge clk);
    rateValid <= 0;
    adcValid <= 0;
    rdc(8'h7C, 8'hA0, OK);
    rdc(8'h80, 8'h5C, OK);
    $display("status registers done");
    rdc(8'hC0, 8'h0F, OK);
    chk(irq, 1'b0);
    wrc(8'hC4, 8'h0F, OK);
    rdc(8'hC4, 8'h0F, OK);
    chk(irq, 1'b1);
    wrc(8'hC0, 8'h0F, OK);
    rdc(8'hC0, 8'h00, OK);
    chk(irq, 1'b0);
    wrc(8'hC8, 8'h03, OK);
    wrc(8'h78, 8'h03, OK);
    pulse(0);
    rdc(8'hC0, 8'h02, OK);
    chk(irq, 1'b1);
    wrc(8'hC0, 8'h02, OK);
    wrc(8'hC8, 8'h01, OK);
    pulse(0);
    rdc(8'hC0, 8'h00, OK);
    $display("interrupt done");
    pulse(1);
    for (i = 0; i < 5; i++) rdc(8'h70 + 8'(4 * i), 8'h00, OK);
    chk(txByteCount, 13'h0);
    chk(txParityEnable, 1'b1);
    $display("set-default done");
    print_verdict;
  end
endmodule
